// *** adw_cpu_model.sv ***
/*
 * Microcontroller-side model: single Avalon-MM transfers to the watchdog register.
 * Assumes one task call at a time from a process synchronous to clk_sys.
 */
`timescale 1ns/1ns
module adw_cpu_model (
	input wire logic clk_sys,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	// ************************************************************
	// Bus transfers
	// ************************************************************
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h1;
	end

	// No wait-state count is assumed; only the bench watchdog ends a hung transfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		// Released data must not look like a held value
		avs_writedata <= ~{24'h000000, d};
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
endmodule

// *** adw_osc.sv ***
/*
 * Low-frequency tick source standing in for the watchdog's own oscillator.
 * Assumes the system clock never stops; the prescaler clears to zero when not enabled.
 */
`timescale 1ns/1ns
module adw_osc
	import adw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic osc_en,
	input wire logic osc_clear,
	output logic osc_tick
);

	localparam logic [7:0] DIV_LAST = 8'(ADW_OSC_DIV - 1);

	typedef struct packed {
		logic [7:0] div;
		logic tick;
	} adw_osc_st_t;

	adw_osc_st_t st_reg;
	adw_osc_st_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		// Restart aligns the first tick with the fresh period
		if (!osc_en || osc_clear) begin
			st_next.div = 8'h00;
		end else if (st_reg.div == DIV_LAST) begin
			st_next.div = 8'h00;
			st_next.tick = 1'b1;
		end else begin
			st_next.div = st_reg.div + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign osc_tick = st_reg.tick & osc_en;

endmodule

// *** adw_pkg.sv ***
/*
 * Shared constants for the autonomous watchdog: register map, field positions,
 * reset values and timing figures.
 * Assumes a 250 MHz system clock and a word-wide Avalon-MM register bus.
 */
package adw_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ADW_CTRL_IDX = 8'h0A;
	localparam logic [7:0] ADW_CTRL_ADDR = 8'h28;
	localparam logic [7:0] ADW_CTRL_RESET = 8'h00;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int ADW_B_RESTART = 5;
	localparam int ADW_B_RST_EN = 4;
	localparam int ADW_B_IRQ_EN = 3;
	localparam int ADW_B_CYC_EN = 2;
	localparam int ADW_B_FLAG = 1;
	localparam int ADW_B_RATE = 0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int ADW_CLK_MHZ = 250;
	localparam int ADW_OSC_TICK_US = 1;
	localparam int ADW_OSC_DIV = ADW_CLK_MHZ * ADW_OSC_TICK_US;
	localparam int ADW_FAST_MS = 10;
	localparam int ADW_SLOW_MS = 20;
	localparam int ADW_FAST_TICKS = ADW_FAST_MS * 1000 / ADW_OSC_TICK_US;
	localparam int ADW_SLOW_TICKS = ADW_SLOW_MS * 1000 / ADW_OSC_TICK_US;
	localparam int ADW_CNT_W = 15;
	localparam logic [2:0] ADW_CHK_SETTLE = 3'h4;
	localparam int ADW_HALL_N = 3;

	typedef enum logic [1:0] {
		ADW_CHK_IDLE,
		ADW_CHK_POWER,
		ADW_CHK_SAMPLE
	} adw_chk_t;

endpackage

// *** adw_sync.sv ***
/*
 * Three-stage synchroniser for pin inputs; the output changes only once
 * the second and third stages agree.
 * Assumes asynchronous inputs and the system clock domain.
 */
`timescale 1ns/1ns
module adw_sync #(
	parameter int W = 3
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} adw_sync_st_t;

	adw_sync_st_t st_reg;
	adw_sync_st_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.q;

endmodule

// *** adw_top.sv ***
/*
 * Autonomous watchdog: control register on Avalon-MM, timeout counter,
 * reset generation in RUN mode, wake-up interrupt and cyclic Hall check in STOP.
 * Assumes stop_mode and hall_irq_en come from logic on clk_sys; hall pins are async.
 */
`timescale 1ns/1ns

// Functional notes
// - Writing one to restart clears the counter; zero does nothing.
// - Restart bit always reads back as zero.
// - Reset enable set lets a timeout raise system reset; clear, never.
// - System reset is only driven in RUN mode.
// - Reset enable takes exactly one write after each reset.
// - Interrupt enable plus flag requests interrupt, only in STOP mode.
// - Cyclic enable turns periodic Hall and analog checking on or off.
// - Flag sets whenever the counter reaches the period end.
// - Writing one clears the flag; writing zero leaves it.
// - Clearing the flag also restarts the counter.
// - Rate bit set gives 10 ms, clear gives 20 ms.
// - Reset zeroes all control bits; upper three bits read zero.
// - Control register at index 0x0A with the six documented fields.
// - Oscillator runs only while interrupt, reset or cyclic enable is set.
// - Reset watchdog pauses in STOP and resumes in RUN.
// - In STOP with interrupt enable, wake after the selected period.
// - Cyclic wake powers and samples Hall inputs; a high one wakes system.
module adw_top
	import adw_pkg::*;
#(
	parameter int FAST_TICKS = ADW_FAST_TICKS,
	parameter int SLOW_TICKS = ADW_SLOW_TICKS
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic stop_mode,
	input wire logic hall_irq_en,
	input wire logic [ADW_HALL_N-1:0] hall_sel,
	input wire logic [ADW_HALL_N-1:0] hall_pin,
	output logic [ADW_HALL_N-1:0] hall_power_en,
	output logic analog_sample,
	output logic regulator_wake,
	output logic sys_reset_req,
	output logic irq_req,
	output logic osc_running
);

	localparam logic [ADW_CNT_W-1:0] FAST_LAST = ADW_CNT_W'(FAST_TICKS - 1);
	localparam logic [ADW_CNT_W-1:0] SLOW_LAST = ADW_CNT_W'(SLOW_TICKS - 1);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic rst_en;
		logic irq_en;
		logic cyc_en;
		logic flag;
		logic rate;
		logic re_locked;
		logic ack;
		logic [7:0] rdata;
		logic [ADW_CNT_W-1:0] cnt;
		adw_chk_t chk;
		logic [2:0] chk_cnt;
		logic hall_wake;
		logic rst_pulse;
		logic sample;
	} adw_st_t;

	adw_st_t st_reg;
	adw_st_t st_next;

	logic [ADW_HALL_N-1:0] hall_sync;
	logic osc_tick;
	logic osc_en;
	logic restart;
	logic timeout;
	logic wr_acc;
	logic rd_first;
	logic hit;
	logic [7:0] wbyte;

	function automatic logic [7:0] ctrl_view(input adw_st_t s);
		ctrl_view = 8'h00;
		ctrl_view[ADW_B_RST_EN] = s.rst_en;
		ctrl_view[ADW_B_IRQ_EN] = s.irq_en;
		ctrl_view[ADW_B_CYC_EN] = s.cyc_en;
		ctrl_view[ADW_B_FLAG] = s.flag;
		ctrl_view[ADW_B_RATE] = s.rate;
	endfunction

	// ************************************************************
	// Submodules
	// ************************************************************
	adw_sync #(
		.W(ADW_HALL_N)
	) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin_in(hall_pin),
		.sync_out(hall_sync)
	);

	adw_osc u_osc (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.osc_en(osc_en),
		.osc_clear(restart),
		.osc_tick(osc_tick)
	);

	// ************************************************************
	// Bus decode: one wait state on every access
	// ************************************************************
	assign hit = (avs_address == ADW_CTRL_ADDR);
	assign wr_acc = avs_write & st_reg.ack & hit & avs_byteenable[0];
	assign rd_first = avs_read & ~st_reg.ack;
	assign wbyte = avs_writedata[7:0];
	assign osc_en = st_reg.irq_en | st_reg.rst_en | st_reg.cyc_en;
	assign restart = wr_acc & (wbyte[ADW_B_RESTART] | wbyte[ADW_B_FLAG]);

	always_comb begin
		logic run_cnt;
		logic [ADW_CNT_W-1:0] last;
		run_cnt = 1'b0;
		last = st_reg.rate ? FAST_LAST : SLOW_LAST;
		st_next = st_reg;
		st_next.rst_pulse = 1'b0;
		st_next.sample = 1'b0;
		st_next.ack = (avs_read | avs_write) & ~st_reg.ack;
		if (rd_first) begin
			st_next.rdata = hit ? ctrl_view(st_reg) : 8'h00;
		end
		// Only the reset-generating function pauses in STOP
		run_cnt = osc_tick & (~stop_mode | st_reg.irq_en | st_reg.cyc_en);
		timeout = run_cnt & (st_reg.cnt == last);
		if (restart) begin
			st_next.cnt = '0;
		end else if (timeout) begin
			st_next.cnt = '0;
		end else if (run_cnt) begin
			st_next.cnt = st_reg.cnt + ADW_CNT_W'(1);
		end
		if (wr_acc) begin
			if (!st_reg.re_locked) begin
				st_next.rst_en = wbyte[ADW_B_RST_EN];
				st_next.re_locked = 1'b1;
			end
			st_next.irq_en = wbyte[ADW_B_IRQ_EN];
			st_next.cyc_en = wbyte[ADW_B_CYC_EN];
			st_next.rate = wbyte[ADW_B_RATE];
			if (wbyte[ADW_B_FLAG]) begin
				st_next.flag = 1'b0;
			end
		end
		// A timeout in the clearing cycle keeps the flag set
		if (timeout) begin
			st_next.flag = 1'b1;
			st_next.rst_pulse = st_reg.rst_en & ~stop_mode;
		end
		if (!stop_mode) begin
			st_next.hall_wake = 1'b0;
		end
		unique case (st_reg.chk)
			ADW_CHK_IDLE: begin
				if (timeout && stop_mode && st_reg.cyc_en) begin
					st_next.chk = ADW_CHK_POWER;
					st_next.chk_cnt = 3'h1;
				end
			end
			ADW_CHK_POWER: begin
				if (st_reg.chk_cnt == ADW_CHK_SETTLE) begin
					st_next.chk = ADW_CHK_SAMPLE;
				end else begin
					st_next.chk_cnt = st_reg.chk_cnt + 3'h1;
				end
			end
			ADW_CHK_SAMPLE: begin
				st_next.chk = ADW_CHK_IDLE;
				st_next.sample = 1'b1;
				if (stop_mode && hall_irq_en && |(hall_sync & hall_sel)) begin
					st_next.hall_wake = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
	assign avs_readdata = {24'h000000, st_reg.rdata};
	assign sys_reset_req = st_reg.rst_pulse;
	// Periodic wake and Hall wake share the one request line
	assign irq_req = stop_mode & ((st_reg.irq_en & st_reg.flag) | st_reg.hall_wake);
	assign regulator_wake = st_reg.hall_wake;
	assign hall_power_en = (st_reg.chk != ADW_CHK_IDLE) ? hall_sel : '0;
	assign analog_sample = st_reg.sample;
	assign osc_running = osc_en;

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_chk_start;
		st_reg.chk == ADW_CHK_IDLE && timeout && stop_mode && st_reg.cyc_en;
	endsequence

	sequence s_chk_power;
		(hall_power_en == hall_sel)[*4];
	endsequence

	AST_RD_RESTART_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(avs_read && !avs_waitrequest) |-> (avs_readdata[ADW_B_RESTART] == 1'b0))
		else $error("restart bit read back as one");

	AST_RD_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(avs_read && !avs_waitrequest) |-> (avs_readdata[31:6] == '0))
		else $error("upper bits not zero");

	AST_RESTART_CLEARS: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_acc && wbyte[ADW_B_RESTART]) |=> (st_reg.cnt == '0))
		else $error("restart did not clear counter");

	AST_FLAG_CLEAR_RESTART: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_acc && wbyte[ADW_B_FLAG] && !timeout) |=> (!st_reg.flag && st_reg.cnt == '0))
		else $error("flag clear did not restart period");

	AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
		timeout |=> st_reg.flag)
		else $error("timeout did not set flag");

	AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(st_reg.flag && !(wr_acc && wbyte[ADW_B_FLAG])) |=> st_reg.flag)
		else $error("flag lost without a clearing write");

	AST_RESET_CAUSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sys_reset_req |-> ($past(timeout) && $past(st_reg.rst_en) && st_reg.flag))
		else $error("reset without enabled timeout");

	AST_RESET_RUN_ONLY: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(timeout && stop_mode) |=> !sys_reset_req)
		else $error("reset raised in stop mode");

	AST_RE_LOCK: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(st_reg.re_locked && wr_acc) |=> $stable(st_reg.rst_en))
		else $error("reset enable changed after first write");

	AST_IRQ_STOP_ONLY: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!stop_mode) |-> !irq_req)
		else $error("interrupt driven in run mode");

	AST_OSC_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!(st_reg.irq_en || st_reg.rst_en || st_reg.cyc_en) && !restart) |->
		(!osc_tick ##1 $stable(st_reg.cnt)))
		else $error("oscillator ticking while disabled");

	AST_STOP_PAUSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(stop_mode && !st_reg.irq_en && !st_reg.cyc_en && !restart) |=> $stable(st_reg.cnt))
		else $error("reset watchdog counted in stop mode");

	AST_CHK_SEQ: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_chk_start |=> s_chk_power ##1 (st_reg.chk == ADW_CHK_SAMPLE))
		else $error("cyclic check sequence broken");

	AST_RE_FIRST_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_acc && !st_reg.re_locked) |=> (st_reg.re_locked && st_reg.rst_en == $past(wbyte[ADW_B_RST_EN])))
		else $error("first write did not load reset enable");

	AST_IRQ_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(stop_mode && st_reg.irq_en && st_reg.flag) |-> irq_req)
		else $error("periodic wake not requested in stop mode");

	AST_HALL_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(st_reg.chk == ADW_CHK_SAMPLE && stop_mode && hall_irq_en && |(hall_sync & hall_sel))
		|=> (regulator_wake && analog_sample))
		else $error("hall hit did not wake the system");

	AST_CHK_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(st_reg.chk == ADW_CHK_IDLE && !st_reg.cyc_en) |=> (st_reg.chk == ADW_CHK_IDLE))
		else $error("cyclic check started while disabled");

	AST_RUN_COUNTS: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!stop_mode && osc_tick && !restart && !timeout) |=>
		(st_reg.cnt == $past(st_reg.cnt) + ADW_CNT_W'(1)))
		else $error("counter did not advance in run mode");

	AST_ZERO_WRITE_KEEPS: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_acc && !wbyte[ADW_B_RESTART] && !wbyte[ADW_B_FLAG] && !osc_tick) |=> $stable(st_reg.cnt))
		else $error("write of zero restart moved the counter");

	AST_ONE_WAIT: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
		else $error("register access held off more than one cycle");

endmodule

// *** autonomous_watchdog_tb.sv ***
/*
 * Self-checking bench for the watchdog: register rows, then timeouts, stop and cyclic check.
 * Assumes shortened periods of 20 and 40 ticks, one tick every 250 clocks.
 */
`timescale 1ns/1ns
module autonomous_watchdog_tb;
	import adw_pkg::*;
	logic clk_sys = 1'b0, reset_n = 1'b0, stop_mode = 1'b0, hall_irq_en = 1'b0;
	logic [2:0] hall_sel = 3'h0, hall_pin = 3'h0;
	logic [7:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, rdv;
	logic [3:0] avs_byteenable;
	logic [2:0] hall_power_en;
	logic analog_sample, regulator_wake, sys_reset_req, irq_req, osc_running;
	int errors = 0, compares = 0, rst_seen = 0, n, base;
	logic [16:0] rows [4] = '{{8'h21, 8'h01, 1'b0}, {8'h18, 8'h08, 1'b1},
		{8'h04, 8'h04, 1'b1}, {8'hC0, 8'h00, 1'b0}};
	wire [3:0] mon = {|hall_power_en, irq_req, sys_reset_req, analog_sample};

	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (sys_reset_req === 1'b1) rst_seen++;

	adw_cpu_model u_adw_cpu_model (.clk_sys(clk_sys), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	adw_top #(.FAST_TICKS(20), .SLOW_TICKS(40)) u_adw_top (.clk_sys(clk_sys),
		.reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
		.hall_irq_en(hall_irq_en), .hall_sel(hall_sel), .hall_pin(hall_pin),
		.hall_power_en(hall_power_en), .analog_sample(analog_sample),
		.regulator_wake(regulator_wake), .sys_reset_req(sys_reset_req),
		.irq_req(irq_req), .osc_running(osc_running));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		u_adw_cpu_model.rd(a, rdv);
		check(rdv, {24'h000000, exp});
	endtask

	task automatic wait_mon(input int which, input int lim);
		n = 0;
		while (mon[which] !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	task automatic in_range(input int lo, input int hi);
		check({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	task automatic do_reset();
		@(posedge clk_sys);
		reset_n <= 1'b0;
		stop_mode <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (80000) @(posedge clk_sys);
		errors++;
		end_sim();
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		rdchk(ADW_CTRL_ADDR, ADW_CTRL_RESET);
		rdchk(8'h2C, 8'h00);
		foreach (rows[i]) begin
			u_adw_cpu_model.wr(ADW_CTRL_ADDR, rows[i][16:9]);
			rdchk(ADW_CTRL_ADDR, rows[i][8:1]);
			check({31'h0, osc_running}, {31'h0, rows[i][0]});
		end
		u_adw_cpu_model.wr(8'h2C, 8'h08);
		rdchk(ADW_CTRL_ADDR, 8'h00);
		$display("test register rows done");
		do_reset();
		u_adw_cpu_model.wr(ADW_CTRL_ADDR, 8'h11);
		wait_mon(1, 6000);
		in_range(4950, 5050);
		rdchk(ADW_CTRL_ADDR, 8'h13);
		u_adw_cpu_model.wr(ADW_CTRL_ADDR, 8'h11);
		rdchk(ADW_CTRL_ADDR, 8'h13);
		u_adw_cpu_model.wr(ADW_CTRL_ADDR, 8'h03);
		rdchk(ADW_CTRL_ADDR, 8'h11);
		wait_mon(1, 6000);
		in_range(4950, 5050);
		// Let the counting process see the pulse before the baseline is taken
		@(posedge clk_sys);
		base = rst_seen;
		repeat (3) begin
			repeat (3000) @(posedge clk_sys);
			u_adw_cpu_model.wr(ADW_CTRL_ADDR, 8'h31);
		end
		check(rst_seen, base);
		$display("test run timeout done");
		stop_mode <= 1'b1;
		repeat (12000) @(posedge clk_sys);
		check(rst_seen, base);
		check({31'h0, irq_req}, 32'h0);
		stop_mode <= 1'b0;
		wait_mon(1, 6000);
		in_range(4700, 5050);
		$display("test stop no reset done");
		do_reset();
		u_adw_cpu_model.wr(ADW_CTRL_ADDR, 8'h08);
		stop_mode <= 1'b1;
		wait_mon(2, 11000);
		in_range(9950, 10050);
		stop_mode <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq_req}, 32'h0);
		$display("test stop wake done");
		do_reset();
		hall_sel <= 3'h2;
		hall_pin <= 3'h2;
		hall_irq_en <= 1'b1;
		u_adw_cpu_model.wr(ADW_CTRL_ADDR, 8'h05);
		stop_mode <= 1'b1;
		wait_mon(3, 6000);
		in_range(4950, 5050);
		@(posedge clk_sys);
		check({29'h0, hall_power_en}, 32'h2);
		wait_mon(0, 20);
		in_range(2, 8);
		@(posedge clk_sys);
		check({30'h0, regulator_wake, irq_req}, 32'h3);
		$display("test cyclic check done");
		end_sim();
	end
endmodule
